// ---- verilog/pmseq_pkg.sv ----
// package: states, widths and reset values of the power mode sequencer
package pmseq_pkg;
  localparam int unsigned RAM_SECTIONS = 6;
  localparam int unsigned WAKE_RST_CYCLES = 4;
  localparam logic [3:0] WAKE_RST_CYCLES_4 = 4'h4;
  localparam logic [1:0] RAM_POWER_RESET = 2'h3;
  localparam logic SUBMODE_LOW_POWER = 1'h0;
  localparam logic SUBMODE_CONST_LAT = 1'h1;

  typedef enum logic [1:0] {
    PMSEQ_RUN = 2'b00,
    PMSEQ_OFF = 2'b01,
    PMSEQ_EMU_OFF = 2'b10,
    PMSEQ_WAKE_RST = 2'b11
  } pmseq_state_t;
endpackage

// ---- verilog/pmseq_ram_if.sv ----
// interface: per-section ram power settings and section supply controls
`timescale 1ns/1ps
`default_nettype none
interface pmseq_ram_if #(parameter int unsigned N = 6);
  logic [N-1:0] power_set;
  logic [N-1:0] retention_set;
  logic [N-1:0] off_state;
  logic [N-1:0] ram_powered;
  logic [N-1:0] ram_retained;
  modport ctrl (output power_set, output retention_set, output off_state,
                input ram_powered, input ram_retained);
  modport ramp (input power_set, input retention_set, input off_state,
                output ram_powered, output ram_retained);
endinterface
`default_nettype wire

// ---- verilog/pmseq_ram_power.sv ----
// ram section power decode
`timescale 1ns/1ps
`default_nettype none
module pmseq_ram_power #(
  parameter int unsigned N = 6
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // settings and results
  pmseq_ram_if.ramp ram
);
  // --------------------------------
  // accessible and retained per section
  // --------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ram.ram_powered <= '1;
      ram.ram_retained <= '1;
    end else begin
      for (int i = 0; i < N; i++) begin
        ram.ram_powered[i] <= !ram.off_state[i] && ram.power_set[i];
        ram.ram_retained[i] <= ram.retention_set[i] |
                               (!ram.off_state[i] && ram.power_set[i]);
      end
    end
  end
endmodule
`default_nettype wire

// ---- verilog/pmseq_top.sv ----
// power mode sequencer: regulator choice, deep-off entry, wake reset
`timescale 1ns/1ps
`default_nettype none
module pmseq_top #(
  parameter int unsigned N = pmseq_pkg::RAM_SECTIONS
) (
  // clock and resets
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic por,
  // software controls
  input wire logic switching_regulator_enable,
  input wire logic deep_off_request,
  input wire logic const_latency_task,
  input wire logic low_power_task,
  input wire logic [N-1:0] ram_power_wr,
  input wire logic [N-1:0] ram_retention_wr,
  input wire logic ram_power_we,
  // wake and debug pins
  input wire logic pin_detect,
  input wire logic debug_mode,
  // regulator and domain controls
  output logic switching_active,
  output logic linear_active,
  output logic core_power_on,
  output logic task_abort,
  output logic system_reset_req,
  output logic debug_domain_on,
  output logic cpu_flash_on,
  output logic in_deep_off,
  output logic in_emulated_off,
  output logic sub_mode,
  // ram sections
  output logic [N-1:0] ram_power_setting,
  output logic [N-1:0] ram_retention_setting,
  output logic [N-1:0] ram_powered,
  output logic [N-1:0] ram_retained
);
  pmseq_pkg::pmseq_state_t state;
  pmseq_pkg::pmseq_state_t next_state;
  logic [1:0] detect_sync;
  logic [1:0] debug_sync;
  logic [3:0] wake_cnt;
  logic wake_done;

  pmseq_ram_if #(.N(N)) ram_if ();

  // --------------------------------
  // state decode
  // --------------------------------
  // real deep-off is the only state that removes core, debug and cpu supplies
  function automatic logic supplies_on(pmseq_pkg::pmseq_state_t s);
    return s != pmseq_pkg::PMSEQ_OFF;
  endfunction

  // entering or holding the wake reset
  function automatic logic wake_reset(pmseq_pkg::pmseq_state_t s);
    return s == pmseq_pkg::PMSEQ_WAKE_RST;
  endfunction

  // --------------------------------
  // pin synchronisers
  // --------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      detect_sync <= 2'h0;
      debug_sync <= 2'h0;
    end else begin
      detect_sync <= {detect_sync[0], pin_detect};
      debug_sync <= {debug_sync[0], debug_mode};
    end
  end

  // --------------------------------
  // power state machine
  // --------------------------------
  assign wake_done = (wake_cnt == pmseq_pkg::WAKE_RST_CYCLES_4 - 4'h1);

  always_comb begin
    next_state = state;
    unique case (state)
      pmseq_pkg::PMSEQ_RUN: begin
        if (deep_off_request) begin
          next_state = debug_sync[1] ? pmseq_pkg::PMSEQ_EMU_OFF
                                     : pmseq_pkg::PMSEQ_OFF;
        end
      end
      pmseq_pkg::PMSEQ_OFF,
      pmseq_pkg::PMSEQ_EMU_OFF: begin
        if (detect_sync[1]) begin
          next_state = pmseq_pkg::PMSEQ_WAKE_RST;
        end
      end
      pmseq_pkg::PMSEQ_WAKE_RST: begin
        if (wake_done) begin
          next_state = pmseq_pkg::PMSEQ_RUN;
        end
      end
    endcase
  end

  // rst wakes the device straight into run; por leaves the state alone
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= pmseq_pkg::PMSEQ_RUN;
    end else begin
      state <= next_state;
    end
  end

  // counts wake reset cycles; rests at zero outside the wake reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wake_cnt <= 4'h0;
    end else if (state == pmseq_pkg::PMSEQ_WAKE_RST) begin
      wake_cnt <= wake_cnt + 4'h1;
    end else begin
      wake_cnt <= 4'h0;
    end
  end

  // --------------------------------
  // regulator selection
  // --------------------------------
  // switching_active is forced low by reset and during the wake reset, else follows switching_regulator_enable
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      switching_active <= 1'b0;
      linear_active <= 1'b1;
    end else if (wake_reset(next_state)) begin
      switching_active <= 1'b0;
      linear_active <= 1'b1;
    end else begin
      switching_active <= switching_regulator_enable;
      linear_active <= !switching_regulator_enable;
    end
  end

  // --------------------------------
  // domain controls
  // --------------------------------
  // outputs follow next_state so they move on the same edge as state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      core_power_on <= 1'b1;
      task_abort <= 1'b0;
      system_reset_req <= 1'b0;
      debug_domain_on <= 1'b1;
      cpu_flash_on <= 1'b1;
      in_deep_off <= 1'b0;
      in_emulated_off <= 1'b0;
    end else begin
      core_power_on <= supplies_on(next_state);
      task_abort <= (state == pmseq_pkg::PMSEQ_RUN) &&
                    (next_state != pmseq_pkg::PMSEQ_RUN);
      system_reset_req <= wake_reset(next_state);
      debug_domain_on <= supplies_on(next_state);
      cpu_flash_on <= supplies_on(next_state);
      in_deep_off <= (next_state == pmseq_pkg::PMSEQ_OFF);
      in_emulated_off <= (next_state == pmseq_pkg::PMSEQ_EMU_OFF);
    end
  end

  // --------------------------------
  // sub power mode
  // --------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sub_mode <= pmseq_pkg::SUBMODE_LOW_POWER;
    end else if (wake_reset(next_state)) begin
      sub_mode <= pmseq_pkg::SUBMODE_LOW_POWER;
    end else if (low_power_task) begin
      sub_mode <= pmseq_pkg::SUBMODE_LOW_POWER;
    end else if (const_latency_task) begin
      sub_mode <= pmseq_pkg::SUBMODE_CONST_LAT;
    end
  end

  // --------------------------------
  // ram power settings
  // --------------------------------
  // only power-on reset restores defaults; rst and wake keep them
  always_ff @(posedge sys_clk) begin
    if (por) begin
      ram_power_setting <= {N{pmseq_pkg::RAM_POWER_RESET[0]}};
      ram_retention_setting <= {N{pmseq_pkg::RAM_POWER_RESET[1]}};
    end else if (ram_power_we && state == pmseq_pkg::PMSEQ_RUN) begin
      ram_power_setting <= ram_power_wr;
      ram_retention_setting <= ram_retention_wr;
    end
  end

  assign ram_if.power_set = ram_power_setting;
  assign ram_if.retention_set = ram_retention_setting;
  assign ram_if.off_state = {N{state == pmseq_pkg::PMSEQ_OFF}};
  assign ram_powered = ram_if.ram_powered;
  assign ram_retained = ram_if.ram_retained;

  pmseq_ram_power #(.N(N)) u_ram (
    .sys_clk(sys_clk),
    .rst(rst),
    .ram(ram_if.ramp)
  );
endmodule
`default_nettype wire

// ---- tb/pmseq_properties.sv ----
// checker: port-level assertions of the power mode sequencer
`timescale 1ns/1ps
`default_nettype none
module pmseq_properties #(parameter int unsigned N = 6) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // controls
  input wire logic switching_regulator_enable,
  input wire logic deep_off_request,
  input wire logic pin_detect,
  input wire logic debug_mode,
  // status
  input wire logic switching_active,
  input wire logic linear_active,
  input wire logic core_power_on,
  input wire logic task_abort,
  input wire logic system_reset_req,
  input wire logic debug_domain_on,
  input wire logic cpu_flash_on,
  input wire logic in_deep_off,
  input wire logic in_emulated_off,
  // ram sections
  input wire logic [N-1:0] ram_power_setting,
  input wire logic [N-1:0] ram_retention_setting,
  input wire logic [N-1:0] ram_powered,
  input wire logic [N-1:0] ram_retained
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic run;
  logic dbg_lo;
  logic dbg_hi;
  assign run = !in_deep_off && !in_emulated_off && !system_reset_req;
  // synced debug level settled over the whole sync depth
  always_ff @(posedge sys_clk) begin
    dbg_lo <= !debug_mode && !$past(debug_mode) && !$past(debug_mode, 2);
    dbg_hi <= debug_mode && $past(debug_mode) && $past(debug_mode, 2);
  end
  a_reg_exclusive: assert property (linear_active != switching_active)
    else $error("regulator outputs not complementary");
  a_switch_needs_en: assert property (switching_active |-> $past(switching_regulator_enable))
    else $error("switching regulator active without enable");
  a_off_entry: assert property (run && deep_off_request && dbg_lo && !debug_mode
    |=> in_deep_off && task_abort && !core_power_on)
    else $error("deep-off entry wrong");
  a_emu_entry: assert property (run && deep_off_request && dbg_hi && debug_mode
    |=> in_emulated_off && !in_deep_off)
    else $error("emulated entry wrong");
  a_emu_keeps_on: assert property (in_emulated_off
    |-> core_power_on && debug_domain_on && cpu_flash_on)
    else $error("domain off in emulated deep-off");
  a_wake_src_only: assert property (in_deep_off && !pin_detect && !$past(pin_detect)
    && !$past(pin_detect, 2) |=> in_deep_off)
    else $error("deep-off left without wake source");
  a_wake_reset_len: assert property ($fell(in_deep_off)
    |-> system_reset_req [*4] ##1 !system_reset_req)
    else $error("wake reset length wrong");
  a_abort_pulse: assert property (task_abort |=> !task_abort)
    else $error("abort longer than one cycle");
  a_ram_off_map: assert property (in_deep_off
    |=> ram_powered == '0 && ram_retained == ram_retention_setting)
    else $error("ram section state wrong in deep-off");
  a_ram_set_kept: assert property (in_deep_off || system_reset_req
    |=> $stable(ram_power_setting) && $stable(ram_retention_setting))
    else $error("ram settings changed");
  a_emu_ram_on: assert property (in_emulated_off && $past(in_emulated_off)
    |-> ram_powered == ram_power_setting)
    else $error("ram section unpowered in emulated deep-off");
  a_wake_sw_off: assert property (system_reset_req |-> !switching_active)
    else $error("switching regulator active in wake reset");
  c_off: cover property (in_deep_off);
  c_emu: cover property (in_emulated_off);
  c_wake: cover property ($fell(system_reset_req));
endmodule
bind pmseq_top pmseq_properties #(.N(N)) u_props (
  .sys_clk(sys_clk),
  .rst(rst),
  .switching_regulator_enable(switching_regulator_enable),
  .deep_off_request(deep_off_request),
  .pin_detect(pin_detect),
  .debug_mode(debug_mode),
  .switching_active(switching_active),
  .linear_active(linear_active),
  .core_power_on(core_power_on),
  .task_abort(task_abort),
  .system_reset_req(system_reset_req),
  .debug_domain_on(debug_domain_on),
  .cpu_flash_on(cpu_flash_on),
  .in_deep_off(in_deep_off),
  .in_emulated_off(in_emulated_off),
  .ram_power_setting(ram_power_setting),
  .ram_retention_setting(ram_retention_setting),
  .ram_powered(ram_powered),
  .ram_retained(ram_retained)
);
`default_nettype wire

// ---- tb/tb_top.sv ----
// testbench: directed scenarios for the power mode sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 0, rst = 1, por = 1, sw_en = 0, req = 0, cl = 0, lp = 0, we = 0;
  logic pin = 0, dbg = 0, sa, la, cpo, ta, srr, ddo, cfo, ido, ieo, sm;
  logic [5:0] pw = 0, rw = 0, ps, rs, rp, rr, n;
  int errors = 0, checks = 0;
  wire [5:0] st = {la, sa, sm, cpo, ido, ieo};
  pmseq_top #(.N(6)) dut_u (.sys_clk(sys_clk), .rst(rst), .por(por),
    .switching_regulator_enable(sw_en), .deep_off_request(req), .const_latency_task(cl),
    .low_power_task(lp), .ram_power_wr(pw), .ram_retention_wr(rw), .ram_power_we(we),
    .pin_detect(pin), .debug_mode(dbg), .switching_active(sa), .linear_active(la),
    .core_power_on(cpo), .task_abort(ta), .system_reset_req(srr), .debug_domain_on(ddo),
    .cpu_flash_on(cfo), .in_deep_off(ido), .in_emulated_off(ieo), .sub_mode(sm),
    .ram_power_setting(ps), .ram_retention_setting(rs), .ram_powered(rp), .ram_retained(rr));
  initial forever #5 sys_clk = ~sys_clk;
  task chk(string nm, logic [5:0] e, logic [5:0] s);
    checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task cyc(int k);
    repeat (k) @(negedge sys_clk);
  endtask
  task go_off(logic d);
    dbg = d;
    cyc(4);
    req = 1;
    cyc(1);
    req = 0;
  endtask
  task wake;
    pin = 1;
    for (int i = 0; i < 10 && srr !== 1'b1; i++) cyc(1);
    pin = 0;
    chk("sw_in_reset", 6'h00, {5'h00, sa});
    n = 0;
    for (int i = 0; i < 10 && srr === 1'b1; i++) begin
      n++;
      cyc(1);
    end
    chk("reset_len", 6'h04, n);
  endtask
  task t_boot;
    chk("boot", 6'h24, st);
    chk("ram_por", 6'h3f, ps & rs);
    sw_en = 1;
    cyc(2);
    chk("switch", 6'h14, st);
    cl = 1;
    cyc(1);
    cl = 0;
    cyc(1);
    chk("const_lat", 6'h1c, st);
    lp = 1;
    cyc(1);
    lp = 0;
    cyc(1);
    chk("low_pwr", 6'h14, st);
    $display("boot test done");
  endtask
  task t_off;
    pw = 6'h0f;
    rw = 6'h05;
    we = 1;
    cyc(1);
    we = 0;
    cl = 1;
    cyc(1);
    cl = 0;
    chk("sub_set", 6'h01, {5'h00, sm});
    go_off(0);
    chk("enter", 6'h05, {3'h0, ta, cpo, ido});
    chk("off_dom", 6'h00, {4'h0, ddo, cfo});
    cyc(1);
    chk("ram_off", 6'h05, rp | rr);
    wake();
    chk("after_wake", {6'h0f}, ps);
    chk("after_ret", 6'h05, rs);
    chk("wake_sub", 6'h00, {5'h00, sm});
    chk("run_again", 6'h04, {3'h0, cpo, ido, ieo});
    $display("off test done");
  endtask
  task t_emu;
    sw_en = 0;
    go_off(1);
    chk("emulated", 6'h1d, {1'b0, cpo, ddo, cfo, ido, ieo});
    cyc(1);
    chk("emu_ram", 6'h0f, rp);
    wake();
    dbg = 0;
    $display("emulated test done");
  endtask
  task t_rst;
    go_off(0);
    pw = 6'h00;
    we = 1;
    cyc(1);
    we = 0;
    cyc(4);
    chk("stay_off", 6'h01, {5'h00, ido});
    rst = 1;
    cyc(2);
    rst = 0;
    cyc(1);
    chk("rst_wake", 6'h04, {3'h0, cpo, ido, ieo});
    chk("rst_kept", 6'h0f, ps);
    $display("reset wake test done");
  endtask
  task close_out;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    errors++;
    close_out();
  end
  initial begin
    cyc(3);
    rst = 0;
    por = 0;
    t_boot();
    t_off();
    t_emu();
    t_rst();
    close_out();
  end
endmodule
`default_nettype wire
